// *** romio_top.sv ***
// Bus-side logic of the ROM and I/O device on a multiplexed bus
`timescale 1ns/1ps
`default_nettype none
`include "romio_defs.svh"
module romio_top
  import romio_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = `ROMIO_ROM_AW,
  parameter int WORDS = `ROMIO_ROM_WORDS
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic port_reset,
  input wire logic addr_latch_strobe,
  input wire logic chip_sel_n,
  input wire logic chip_sel,
  input wire logic io_mem_sel,
  input wire logic [AW-DW-1:0] upper_rom_address,
  input wire logic read_strobe_n,
  input wire logic port_read_strobe_n,
  input wire logic port_write_strobe_n,
  input wire logic [DW-1:0] addr_data_bus_in,
  output logic [DW-1:0] addr_data_bus_out,
  output logic addr_data_bus_oe,
  output logic ready_out,
  output logic ready_oe,
  input wire logic [DW-1:0] port_a_pins_in,
  output logic [DW-1:0] port_a_pins_out,
  output logic [DW-1:0] port_a_pins_oe,
  input wire logic [DW-1:0] port_b_pins_in,
  output logic [DW-1:0] port_b_pins_out,
  output logic [DW-1:0] port_b_pins_oe
);
  logic rst_meta_reg;
  logic rst_sync_b;
  logic [AW-1:0] addr_reg;
  logic io_sel_reg;
  logic sel_ok_reg;
  logic [DW-1:0] rom_mem [0:WORDS-1];
  logic [DW-1:0] rom_word;
  logic [DW-1:0] a_data, a_dir, b_data, b_dir;
  logic [DW-1:0] port_word;
  logic port_read;
  logic read_active;
  logic cs_live;
  logic wr_en;
  logic wr_a_data;
  logic wr_a_dir;
  logic wr_b_data;
  logic wr_b_dir;
  logic pick_b;
  logic pick_dir;
  romio_src_t src;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b <= rst_meta_reg;
    end
  end

  // Loaded on every clock while strobe high, held after it falls
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      addr_reg <= '0;
      io_sel_reg <= 1'b0;
      sel_ok_reg <= 1'b0;
    end else if (addr_latch_strobe) begin
      addr_reg <= {upper_rom_address, addr_data_bus_in};
      io_sel_reg <= io_mem_sel;
      sel_ok_reg <= chip_sel && !chip_sel_n;
    end
  end

  // Mask contents are fixed at build; fill value stands in
  initial begin
    for (int k = 0; k < WORDS; k++) begin
      rom_mem[k] = DW'(`ROMIO_ROM_FILL);
    end
  end
  assign rom_word = rom_mem[addr_reg];

  assign pick_b = addr_reg[`ROMIO_PORT_SEL_BIT];
  assign pick_dir = addr_reg[`ROMIO_REG_SEL_BIT];
  assign cs_live = sel_ok_reg && !addr_latch_strobe;
  assign port_read = !port_read_strobe_n || io_sel_reg;
  assign read_active = cs_live && (!read_strobe_n || !port_read_strobe_n);
  assign src = port_read ? romio_src_port_t_v : romio_src_rom_t_v;
  assign wr_en = cs_live && !port_write_strobe_n;
  // Latched bits 0 and 1 pick the target; upper bits never reach a port
  assign wr_a_data = wr_en && !pick_b && !pick_dir;
  assign wr_a_dir = wr_en && !pick_b && pick_dir;
  assign wr_b_data = wr_en && pick_b && !pick_dir;
  assign wr_b_dir = wr_en && pick_b && pick_dir;

  always_comb begin
    unique case ({pick_dir, pick_b})
      2'b00: port_word = a_data;
      2'b01: port_word = b_data;
      2'b10: port_word = a_dir;
      2'b11: port_word = b_dir;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      addr_data_bus_oe <= 1'b0;
      addr_data_bus_out <= '0;
    end else begin
      addr_data_bus_oe <= read_active;
      addr_data_bus_out <= (src == romio_src_port_t_v) ? port_word : rom_word;
    end
  end

  // Wait driven low from the clock after strobe-time select until the clock after the strobe falls
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ready_oe <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      ready_oe <= addr_latch_strobe && chip_sel && !chip_sel_n;
      ready_out <= 1'b0;
    end
  end

  romio_port #(.W(DW)) u_port_a (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .port_reset(port_reset),
    .wr_data(wr_a_data),
    .wr_dir(wr_a_dir),
    .wdata(addr_data_bus_in),
    .pins_in(port_a_pins_in),
    .pins_out(port_a_pins_out),
    .pins_oe(port_a_pins_oe),
    .rd_data(a_data),
    .rd_dir(a_dir)
  );
  romio_port #(.W(DW)) u_port_b (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .port_reset(port_reset),
    .wr_data(wr_b_data),
    .wr_dir(wr_b_dir),
    .wdata(addr_data_bus_in),
    .pins_in(port_b_pins_in),
    .pins_out(port_b_pins_out),
    .pins_oe(port_b_pins_oe),
    .rd_data(b_data),
    .rd_dir(b_dir)
  );

  // Bus drive follows the strobes one clock late
  a_bus_float: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (read_strobe_n && port_read_strobe_n) |=> !addr_data_bus_oe)
    else $error("bus driven idle");
  a_bus_drive: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    read_active |=> addr_data_bus_oe)
    else $error("bus not driven on read");
  a_no_select: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    !sel_ok_reg |=> !addr_data_bus_oe)
    else $error("unselected chip drove bus");
  a_bus_quiet: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    !cs_live |=> !addr_data_bus_oe)
    else $error("bus driven while latch open");

  // Wait output
  a_wait_low: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (addr_latch_strobe && chip_sel && !chip_sel_n) |=> (ready_oe && !ready_out))
    else $error("wait not asserted");
  a_wait_release: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    !addr_latch_strobe |=> !ready_oe)
    else $error("wait not released");
  a_wait_unsel: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    !(chip_sel && !chip_sel_n) |=> !ready_oe)
    else $error("unselected chip drove wait");

  // Address latch
  a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    !addr_latch_strobe |=> $stable(addr_reg))
    else $error("address moved after latch");
  a_latch_capture: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    addr_latch_strobe |=> (addr_reg[DW-1:0] == $past(addr_data_bus_in))
      && (addr_reg[AW-1:DW] == $past(upper_rom_address)) && (io_sel_reg == $past(io_mem_sel)))
    else $error("address not captured");

  // Read source selection
  a_port_read: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (read_active && !port_read_strobe_n) |=> addr_data_bus_out == $past(port_word))
    else $error("port read wrong source");
  a_io_read: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (read_active && io_sel_reg) |=> addr_data_bus_out == $past(port_word))
    else $error("io read wrong source");
  a_rom_read: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (read_active && port_read_strobe_n && !io_sel_reg) |=> addr_data_bus_out == $past(rom_word))
    else $error("rom read wrong source");
  a_dir_read_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (read_active && port_read && pick_dir && !pick_b && !port_reset) |=> (addr_data_bus_out == port_a_pins_oe))
    else $error("direction read of port A wrong");
  a_dir_read_b: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (read_active && port_read && pick_dir && pick_b && !port_reset) |=> (addr_data_bus_out == port_b_pins_oe))
    else $error("direction read of port B wrong");
  a_out_read_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (read_active && port_read && !pick_dir && !pick_b)
      |=> (((addr_data_bus_out ^ port_a_pins_out) & $past(a_dir)) == '0))
    else $error("output bits of port A read wrong");

  // Port writes reach the pins two clocks later
  a_write_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    wr_a_data |=> ##1 (port_a_pins_out == $past(addr_data_bus_in, 2)))
    else $error("port A write lost");
  a_write_b: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    wr_b_data |=> ##1 (port_b_pins_out == $past(addr_data_bus_in, 2)))
    else $error("port B write lost");
  a_dir_write_a: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (wr_a_dir && !port_reset) ##1 !port_reset |=> (port_a_pins_oe == $past(addr_data_bus_in, 2)))
    else $error("port A direction write lost");
  a_dir_write_b: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    (wr_b_dir && !port_reset) ##1 !port_reset |=> (port_b_pins_oe == $past(addr_data_bus_in, 2)))
    else $error("port B direction write lost");
endmodule : romio_top
`default_nettype wire

// *** romio_defs.svh ***
// Constants for the ROM and I/O bus port: ROM size, decode bits, reset and fill values
`ifndef ROMIO_DEFS_SVH
`define ROMIO_DEFS_SVH
`define ROMIO_ROM_WORDS 2048
`define ROMIO_ROM_AW 11
`define ROMIO_PORT_SEL_BIT 0
`define ROMIO_REG_SEL_BIT 1
`define ROMIO_DATA_RESET 8'h00
`define ROMIO_DIR_RESET 8'h00
`define ROMIO_ROM_FILL 8'hff
`endif

// *** romio_pkg.sv ***
// Types shared by the ROM and I/O bus port
`default_nettype none
package romio_pkg;
  typedef enum logic [1:0] {
    romio_src_rom_t_v = 2'b00,
    romio_src_port_t_v = 2'b01
  } romio_src_t;
endpackage : romio_pkg
`default_nettype wire

// *** romio_port.sv ***
// One 8-bit general purpose port with per-bit direction
`timescale 1ns/1ps
`default_nettype none
`include "romio_defs.svh"
module romio_port #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst_sync_b,
  input wire logic port_reset,
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] pins_out,
  output logic [W-1:0] pins_oe,
  output logic [W-1:0] rd_data,
  output logic [W-1:0] rd_dir
);
  logic [W-1:0] data_reg;
  logic [W-1:0] dir_reg;

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_reg <= W'(`ROMIO_DATA_RESET);
    end else if (wr_data) begin
      data_reg <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dir_reg <= W'(`ROMIO_DIR_RESET);
    end else if (port_reset) begin
      dir_reg <= W'(`ROMIO_DIR_RESET);
    end else if (wr_dir) begin
      dir_reg <= wdata;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Registered so pins come straight from flip-flops
      always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          pins_oe[i] <= 1'b0;
          pins_out[i] <= 1'b0;
        end else begin
          pins_oe[i] <= dir_reg[i] && !port_reset;
          pins_out[i] <= data_reg[i];
        end
      end
      assign rd_data[i] = dir_reg[i] ? data_reg[i] : pins_in[i];
    end
  endgenerate
  assign rd_dir = dir_reg;

  a_reset_inputs: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    port_reset |=> (pins_oe == '0)) else $error("port drives during reset");
  a_dir_drive: assert property (@(posedge mclk) disable iff (!rst_sync_b)
    !port_reset && !$past(port_reset) |-> (pins_oe == $past(dir_reg)))
    else $error("pin enable does not follow direction");
endmodule : romio_port
`default_nettype wire

// *** romio_cpu_model.sv ***
// Processor side of the multiplexed bus: one task per bus cycle
`timescale 1ns/1ps
`default_nettype none
module romio_cpu_model (
  input wire logic mclk,
  output logic ale,
  output logic cs_n,
  output logic cs,
  output logic io,
  output logic [2:0] up,
  output logic rd_n,
  output logic ior_n,
  output logic iow_n,
  output logic [7:0] bus,
  input wire logic [7:0] bus_q,
  input wire logic bus_oe,
  input wire logic rdy_oe,
  input wire logic rdy_q
);
  initial begin
    {ale, cs, io, up, bus} = '0;
    {cs_n, rd_n, ior_n, iow_n} = 4'hf;
  end
  // k: 0 memory read, 1 port read, 2 port write
  task automatic xfer(input logic [10:0] a, input logic i, input logic s, input int k,
      input logic [7:0] wd, output logic [7:0] rd, output logic oe, output logic rdy);
    @(posedge mclk); #1;
    {ale, bus, up, io, cs_n, cs} = {1'b1, a[7:0], a[10:8], i, !s, s};
    @(posedge mclk); #1;
    rdy = rdy_oe && !rdy_q;
    @(posedge mclk); #1;
    ale = 1'b0;
    // Released address lines show the inverse, not a stale copy
    bus = ~a[7:0];
    @(posedge mclk); #1;
    rd_n = (k != 0);
    ior_n = (k != 1);
    iow_n = (k != 2);
    if (k == 2) bus = wd;
    @(posedge mclk); #1;
    rd = bus_q;
    oe = bus_oe;
    {rd_n, ior_n, iow_n} = 3'h7;
    bus = ~bus;
    @(posedge mclk); #1;
  endtask : xfer
endmodule : romio_cpu_model
`default_nettype wire

// *** rom_io_multiplexed_bus_port_tb.sv ***
// Self-checking bench for the ROM and I/O bus port
`timescale 1ns/1ps
`default_nettype none
`include "romio_defs.svh"
module rom_io_multiplexed_bus_port_tb;
  logic mclk, rst_b, port_reset, ale, cs_n, cs, io, rd_n, ior_n, iow_n, b_oe, r_oe, r_q, oe, rdy;
  logic [2:0] up;
  logic [7:0] bus, b_q, rd, d, dir, pa_q, pa_oe, pb_q, pb_oe, ext_a, ext_b, pa_in, pb_in;
  int errors, tests_run;
  assign pa_in = (pa_q & pa_oe) | (ext_a & ~pa_oe);
  assign pb_in = (pb_q & pb_oe) | (ext_b & ~pb_oe);
  romio_top dut_u (.mclk(mclk), .rst_b(rst_b), .port_reset(port_reset), .addr_latch_strobe(ale),
    .chip_sel_n(cs_n), .chip_sel(cs), .io_mem_sel(io), .upper_rom_address(up), .read_strobe_n(rd_n),
    .port_read_strobe_n(ior_n), .port_write_strobe_n(iow_n), .addr_data_bus_in(bus),
    .addr_data_bus_out(b_q), .addr_data_bus_oe(b_oe), .ready_out(r_q), .ready_oe(r_oe),
    .port_a_pins_in(pa_in), .port_a_pins_out(pa_q), .port_a_pins_oe(pa_oe),
    .port_b_pins_in(pb_in), .port_b_pins_out(pb_q), .port_b_pins_oe(pb_oe));
  romio_cpu_model cpu_u (.mclk(mclk), .ale(ale), .cs_n(cs_n), .cs(cs), .io(io), .up(up), .rd_n(rd_n),
    .ior_n(ior_n), .iow_n(iow_n), .bus(bus), .bus_q(b_q), .bus_oe(b_oe), .rdy_oe(r_oe), .rdy_q(r_q));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  function automatic logic [7:0] port_exp(input logic [7:0] q, input logic [7:0] m, input logic [7:0] e);
    return (q & m) | (e & ~m);
  endfunction : port_exp
  initial begin
    #500000;
    errors++;
    test_done();
  end
  initial begin
    {rst_b, port_reset, ext_a, ext_b} = '0;
    repeat (4) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (5) @(posedge mclk);
    void'($urandom(32'h509ae675));
    for (int n = 0; n < 8; n++) begin
      cpu_u.xfer(11'($urandom), 1'b0, 1'b1, 0, 8'h00, rd, oe, rdy);
      check(rd, `ROMIO_ROM_FILL);
      check({7'h0, oe}, 8'h01);
      check({7'h0, rdy}, 8'h01);
      check({7'h0, b_oe}, 8'h00);
    end
    $display("test rom read done");
    for (int p = 0; p < 2; p++) begin
      d = 8'($urandom);
      dir = 8'($urandom);
      cpu_u.xfer({3'($urandom), 7'h0, 1'(p)}, 1'($urandom), 1'b1, 2, d, rd, oe, rdy);
      cpu_u.xfer({3'($urandom), 7'h1, 1'(p)}, 1'($urandom), 1'b1, 2, dir, rd, oe, rdy);
      cpu_u.xfer({10'h1, 1'(p)}, 1'b1, 1'b0, 2, ~dir, rd, oe, rdy);
      check({7'h0, oe | rdy}, 8'h00);
      ext_a = 8'($urandom);
      ext_b = 8'($urandom);
      check(p ? pb_oe : pa_oe, dir);
      check((p ? pb_q : pa_q) & dir, d & dir);
      cpu_u.xfer({3'h7, 7'h0, 1'(p)}, 1'b0, 1'b1, 1, 8'h00, rd, oe, rdy);
      check(rd, port_exp(d, dir, p ? ext_b : ext_a));
      cpu_u.xfer({3'h0, 7'h0, 1'(p)}, 1'b1, 1'b1, 0, 8'h00, rd, oe, rdy);
      check(rd, port_exp(d, dir, p ? ext_b : ext_a));
      cpu_u.xfer({10'h1, 1'(p)}, 1'b0, 1'b1, 1, 8'h00, rd, oe, rdy);
      check(rd, dir);
    end
    $display("test port access done");
    cpu_u.xfer({10'h1, 1'b0}, 1'b1, 1'b1, 2, 8'hff, rd, oe, rdy);
    check(pa_oe, 8'hff);
    @(posedge mclk);
    #1 port_reset = 1'b1;
    repeat (3) @(posedge mclk);
    #1 check(pa_oe | pb_oe, 8'h00);
    port_reset = 1'b0;
    cpu_u.xfer({10'h1, 1'b0}, 1'b1, 1'b1, 0, 8'h00, rd, oe, rdy);
    check(rd, `ROMIO_DIR_RESET);
    $display("test port reset done");
    test_done();
  end
endmodule : rom_io_multiplexed_bus_port_tb
`default_nettype wire
